//--- core/crpc_map.vh
// Behaviour
// - writing one to bit 0 of page 0 register 1 resets like the pin
// - after any reset, memory initialization completes within 1 ms of release
// - derived clocks are withheld about 10 ms after synthesizer power-up
// - stage reset re-enables a tripped output stage, other registers untouched
// - page 1 register 31 bit 7 resets left, bit 6 right headphone stage
// - page 1 register 32 bit 7 resets left, bit 6 right speaker pair
// - every block is powered down after any reset
// - software writes to the power register power each block up
// - powering down leaves all register settings unchanged
// - registers are eight bits and writable ones read back, except register 1 and the self-clearing stage reset bits, which read zero
`ifndef CRPC_MAP_VH
`define CRPC_MAP_VH

// ****************************************
// register map
// ****************************************
`define CRPC_PAGE_SEL_ADDR 8'h00
`define CRPC_SW_RESET_ADDR 8'h01
`define CRPC_STATUS_ADDR 8'h02
`define CRPC_POWER_ADDR 8'h09
`define CRPC_HP_RESET_ADDR 8'h1f
`define CRPC_SPK_RESET_ADDR 8'h20
`define CRPC_PAGE0 8'h00
`define CRPC_PAGE1 8'h01
`define CRPC_REG_RESET 8'h00

// ****************************************
// field positions
// ****************************************
`define CRPC_SW_RESET_BIT 0
`define CRPC_LEFT_RESET_BIT 7
`define CRPC_RIGHT_RESET_BIT 6
`define CRPC_PWR_PLL_BIT 7
`define CRPC_PWR_ADC_BIT 5
`define CRPC_PWR_DAC_BIT 4
`define CRPC_STAT_INIT_BIT 0
`define CRPC_STAT_CLK_BIT 1
`define CRPC_STAT_TRIP_LSB 4
`define CRPC_STAGE_CNT 4
`define CRPC_STAGE_HPL 3
`define CRPC_STAGE_HPR 2
`define CRPC_STAGE_SPKL 1
`define CRPC_STAGE_SPKR 0

// ****************************************
// timing
// ****************************************
`define CRPC_CLK_MHZ 18'h00014
`define CRPC_INIT_US 18'h003e8
`define CRPC_PLL_US 18'h02710
// sync and pipeline cycles come off the count so the lockout ends inside its limit
`define CRPC_INIT_LAT 18'h00008
`define CRPC_INIT_CYC (`CRPC_INIT_US * `CRPC_CLK_MHZ - `CRPC_INIT_LAT)
`define CRPC_PLL_CYC (`CRPC_PLL_US * `CRPC_CLK_MHZ)
`define CRPC_CNT_W 18

`endif

//--- core/crpc_sync.v
// ****************************************
// two-stage synchronizer for pin levels
// ****************************************
module crpc_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk,
  input wire sys_rst,
  input wire din,
  output reg dout
);
  reg stage1;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // crpc_sync

//--- core/crpc_delay.v
`include "crpc_map.vh"

// ****************************************
// reloadable countdown, busy while nonzero
// ****************************************
module crpc_delay #(
  parameter [`CRPC_CNT_W-1:0] CYCLES = 18'h00001,
  parameter [0:0] START_BUSY = 1'b0
) (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire stop,
  output wire busy
);
  reg [`CRPC_CNT_W-1:0] count;

  assign busy = |count;

  // start has priority so a held request keeps the count full
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= START_BUSY ? CYCLES : {`CRPC_CNT_W{1'b0}};
    end else if (start) begin
      count <= CYCLES;
    end else if (stop) begin
      count <= {`CRPC_CNT_W{1'b0}};
    end else if (busy) begin
      count <= count - {{(`CRPC_CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // crpc_delay

//--- core/crpc_top.v
`include "crpc_map.vh"

module crpc_top #(
  parameter [`CRPC_CNT_W-1:0] INIT_CYCLES = `CRPC_INIT_CYC,
  parameter [`CRPC_CNT_W-1:0] PLL_CYCLES = `CRPC_PLL_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire hw_reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire trip_left_headphone_driver,
  input wire trip_right_headphone_driver,
  input wire trip_left_speaker,
  input wire trip_right_speaker,
  output reg init_busy,
  output reg clocks_ready,
  output reg pll_power,
  output reg adc_power,
  output reg dac_power,
  output reg left_headphone_driver_en,
  output reg right_headphone_driver_en,
  output reg left_speaker_en,
  output reg right_speaker_en
);

  // ****************************************
  // decode helper
  // ****************************************
  function hit;
    input [7:0] cur_page;
    input [7:0] addr;
    input [7:0] want_page;
    input [7:0] want_addr;
    begin
      hit = (cur_page == want_page) && (addr == want_addr);
    end
  endfunction

  // ****************************************
  // pin synchronizers
  // ****************************************
  wire pin_rst_n;
  wire [`CRPC_STAGE_CNT-1:0] trip_raw;
  wire [`CRPC_STAGE_CNT-1:0] trip_sync;

  assign trip_raw = {trip_left_headphone_driver, trip_right_headphone_driver,
                     trip_left_speaker, trip_right_speaker};

  reg pin_seen_n;

  // the pin clears this flop directly, so a low pulse far shorter than a clock
  // still leaves a mark that the synchronizer below is sure to see
  always @(posedge clk or posedge sys_rst or negedge hw_reset_n) begin
    if (sys_rst) begin
      pin_seen_n <= 1'b0;
    end else if (!hw_reset_n) begin
      pin_seen_n <= 1'b0;
    end else begin
      pin_seen_n <= 1'b1;
    end
  end

  crpc_sync #(.RST_VAL(1'b0)) u_rst_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(pin_seen_n),
    .dout(pin_rst_n)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CRPC_STAGE_CNT; gi = gi + 1) begin : g_trip_sync
      crpc_sync #(.RST_VAL(1'b0)) u_trip_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(trip_raw[gi]),
        .dout(trip_sync[gi])
      );
    end
  endgenerate

  // ****************************************
  // reset sequencing
  // ****************************************
  reg [7:0] page;
  reg soft_rst;
  wire logic_clear;
  wire wr_sw_reset;

  assign wr_sw_reset = reg_wr && hit(page, reg_addr, `CRPC_PAGE0, `CRPC_SW_RESET_ADDR) &&
                       reg_wdata[`CRPC_SW_RESET_BIT];
  assign logic_clear = ~pin_rst_n | soft_rst;

  // the request is held for one cycle, then its own feedback drops it back to zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_sw_reset & ~soft_rst;
    end
  end

  wire init_run;

  // count restarts while the clear is held and runs out after release
  crpc_delay #(.CYCLES(INIT_CYCLES), .START_BUSY(1'b1)) u_init (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(logic_clear),
    .stop(1'b0),
    .busy(init_run)
  );

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] power_ctrl;
  reg [7:0] hp_reset;
  reg [7:0] spk_reset;
  wire wr_power;
  wire wr_hp;
  wire wr_spk;

  assign wr_power = reg_wr && hit(page, reg_addr, `CRPC_PAGE1, `CRPC_POWER_ADDR);
  assign wr_hp = reg_wr && hit(page, reg_addr, `CRPC_PAGE1, `CRPC_HP_RESET_ADDR);
  assign wr_spk = reg_wr && hit(page, reg_addr, `CRPC_PAGE1, `CRPC_SPK_RESET_ADDR);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page <= `CRPC_REG_RESET;
      power_ctrl <= `CRPC_REG_RESET;
      hp_reset <= `CRPC_REG_RESET;
      spk_reset <= `CRPC_REG_RESET;
    end else if (logic_clear) begin
      page <= `CRPC_REG_RESET;
      power_ctrl <= `CRPC_REG_RESET;
      hp_reset <= `CRPC_REG_RESET;
      spk_reset <= `CRPC_REG_RESET;
    end else begin
      if (reg_wr && reg_addr == `CRPC_PAGE_SEL_ADDR) begin
        page <= reg_wdata;
      end
      // only this register holds power state, so power-down touches nothing else
      if (wr_power) begin
        power_ctrl <= reg_wdata;
      end
      // stage reset bits live one cycle; the other bits are plain storage
      if (wr_hp) begin
        hp_reset <= reg_wdata;
      end else begin
        hp_reset[`CRPC_LEFT_RESET_BIT] <= 1'b0;
        hp_reset[`CRPC_RIGHT_RESET_BIT] <= 1'b0;
      end
      if (wr_spk) begin
        spk_reset <= reg_wdata;
      end else begin
        spk_reset[`CRPC_LEFT_RESET_BIT] <= 1'b0;
        spk_reset[`CRPC_RIGHT_RESET_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // overcurrent latches
  // ****************************************
  wire [`CRPC_STAGE_CNT-1:0] stage_clear;
  wire [`CRPC_STAGE_CNT-1:0] stage_power;
  wire [`CRPC_STAGE_CNT-1:0] tripped;
  wire [`CRPC_STAGE_CNT-1:0] next_en;

  assign stage_clear = {hp_reset[`CRPC_LEFT_RESET_BIT], hp_reset[`CRPC_RIGHT_RESET_BIT],
                        spk_reset[`CRPC_LEFT_RESET_BIT],
                        spk_reset[`CRPC_RIGHT_RESET_BIT]};
  assign stage_power = power_ctrl[`CRPC_STAGE_CNT-1:0];

  generate
    for (gi = 0; gi < `CRPC_STAGE_CNT; gi = gi + 1) begin : g_trip
      reg trip_latch;

      assign tripped[gi] = trip_latch;
      // a stage runs only when powered, untripped and past initialization
      assign next_en[gi] = stage_power[gi] & ~trip_latch & ~init_run;
      // a trip in the clearing cycle wins, so the stage stays off
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          trip_latch <= 1'b0;
        end else if (trip_sync[gi]) begin
          trip_latch <= 1'b1;
        end else if (stage_clear[gi] | logic_clear) begin
          trip_latch <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // clock synthesizer settle
  // ****************************************
  reg pll_req_d;
  wire pll_req;
  wire pll_settling;

  // nothing powers up while memories are still being initialized
  assign pll_req = power_ctrl[`CRPC_PWR_PLL_BIT] & ~init_run;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_req_d <= 1'b0;
    end else begin
      pll_req_d <= pll_req;
    end
  end

  crpc_delay #(.CYCLES(PLL_CYCLES), .START_BUSY(1'b0)) u_pll (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(pll_req & ~pll_req_d),
    .stop(~pll_req),
    .busy(pll_settling)
  );

  // ****************************************
  // outputs
  // ****************************************
  reg [7:0] status;

  // spare status bits read as zero
  always @* begin
    status = `CRPC_REG_RESET;
    status[`CRPC_STAT_INIT_BIT] = init_busy;
    status[`CRPC_STAT_CLK_BIT] = clocks_ready;
    status[`CRPC_STAT_TRIP_LSB +: `CRPC_STAGE_CNT] = tripped;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_busy <= 1'b1;
      clocks_ready <= 1'b0;
      pll_power <= 1'b0;
      adc_power <= 1'b0;
      dac_power <= 1'b0;
      left_headphone_driver_en <= 1'b0;
      right_headphone_driver_en <= 1'b0;
      left_speaker_en <= 1'b0;
      right_speaker_en <= 1'b0;
    end else begin
      init_busy <= init_run | logic_clear;
      clocks_ready <= pll_req & pll_req_d & ~pll_settling;
      pll_power <= pll_req;
      adc_power <= power_ctrl[`CRPC_PWR_ADC_BIT] & ~init_run;
      dac_power <= power_ctrl[`CRPC_PWR_DAC_BIT] & ~init_run;
      left_headphone_driver_en <= next_en[`CRPC_STAGE_HPL];
      right_headphone_driver_en <= next_en[`CRPC_STAGE_HPR];
      left_speaker_en <= next_en[`CRPC_STAGE_SPKL];
      right_speaker_en <= next_en[`CRPC_STAGE_SPKR];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  reg [7:0] next_rdata;

  // the page register answers on every page; anything unmapped reads zero
  always @* begin
    next_rdata = `CRPC_REG_RESET;
    if (reg_addr == `CRPC_PAGE_SEL_ADDR) begin
      next_rdata = page;
    end else if (page == `CRPC_PAGE0) begin
      case (reg_addr)
        `CRPC_SW_RESET_ADDR: begin
          next_rdata = `CRPC_REG_RESET;
        end
        `CRPC_STATUS_ADDR: begin
          next_rdata = status;
        end
        default: begin
          next_rdata = `CRPC_REG_RESET;
        end
      endcase
    end else if (page == `CRPC_PAGE1) begin
      case (reg_addr)
        `CRPC_POWER_ADDR: begin
          next_rdata = power_ctrl;
        end
        `CRPC_HP_RESET_ADDR: begin
          next_rdata = hp_reset;
        end
        `CRPC_SPK_RESET_ADDR: begin
          next_rdata = spk_reset;
        end
        default: begin
          next_rdata = `CRPC_REG_RESET;
        end
      endcase
    end
  end

  // read data holds between reads, so a slow front end may fetch it late
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `CRPC_REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // crpc_top

//--- tb/crpc_checker.sv
`include "crpc_map.vh"

module crpc_checker #(
  parameter [`CRPC_CNT_W-1:0] INIT_CYCLES = `CRPC_INIT_CYC,
  parameter [`CRPC_CNT_W-1:0] PLL_CYCLES = `CRPC_PLL_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire hw_reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire trip_left_headphone_driver,
  input wire trip_right_headphone_driver,
  input wire trip_left_speaker,
  input wire trip_right_speaker,
  input wire init_busy,
  input wire clocks_ready,
  input wire pll_power,
  input wire adc_power,
  input wire dac_power,
  input wire left_headphone_driver_en,
  input wire right_headphone_driver_en,
  input wire left_speaker_en,
  input wire right_speaker_en
);
  wire [3:0] en = {left_headphone_driver_en, right_headphone_driver_en, left_speaker_en,
    right_speaker_en};
  // ****************************************
  // cycle counters for the long waits
  // ****************************************
  reg [17:0] pll_cnt;
  reg [17:0] busy_cnt;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_cnt <= 18'h00000;
      busy_cnt <= 18'h00000;
    end else begin
      // saturates so a long powered run never wraps back below the threshold
      pll_cnt <= pll_power ? pll_cnt + {17'h00000, pll_cnt != 18'h3ffff} : 18'h00000;
      busy_cnt <= (init_busy && hw_reset_n) ? busy_cnt + 18'h00001 : 18'h00000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  lock_gate_a: assert property (init_busy && $past(init_busy)
    |-> !pll_power && !adc_power && !dac_power && en == 4'h0) else $error("power during init");
  pll_wait_a: assert property (clocks_ready |-> pll_cnt >= PLL_CYCLES - 2)
    else $error("clocks ready too early");
  pll_ready_a: assert property (pll_cnt == PLL_CYCLES + 4 |-> clocks_ready)
    else $error("clocks ready too late");
  clk_drop_a: assert property (!pll_power [*2] |-> !clocks_ready)
    else $error("clocks ready without synthesizer");
  hp_trip_a: assert property (trip_left_headphone_driver [*5] |-> !left_headphone_driver_en)
    else $error("tripped stage still enabled");
  spk_trip_a: assert property (trip_right_speaker [*5] |-> !right_speaker_en)
    else $error("tripped speaker still enabled");
  pin_hold_a: assert property (!hw_reset_n [*5] |-> init_busy)
    else $error("no lockout under reset pin");
  init_len_a: assert property (busy_cnt <= INIT_CYCLES + 6)
    else $error("initialization too long");
  swr_zero_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00)
    else $error("reset bit reads nonzero");
  rdata_hold_a: assert property (!reg_rd && !init_busy |=> init_busy || $stable(reg_rdata))
    else $error("read data changed without read");

  cover property ($fell(init_busy));
  cover property ($rose(clocks_ready));
  cover property ($fell(left_headphone_driver_en) && pll_power);
endmodule // crpc_checker

bind crpc_top crpc_checker #(.INIT_CYCLES(INIT_CYCLES), .PLL_CYCLES(PLL_CYCLES)) i_crpc_checker (.*);

//--- tb/crpc_top_test.sv
module crpc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [17:0] INIT = 18'h00014;
  localparam [17:0] PLL = 18'h00032;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] trip = 4'h0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  wire [7:0] reg_rdata;
  wire init_busy, clocks_ready, pll_power, adc_power, dac_power;
  wire left_headphone_driver_en, right_headphone_driver_en, left_speaker_en, right_speaker_en;
  wire trip_left_headphone_driver = trip[3];
  wire trip_right_headphone_driver = trip[2];
  wire trip_left_speaker = trip[1];
  wire trip_right_speaker = trip[0];
  wire [3:0] en = {left_headphone_driver_en, right_headphone_driver_en, left_speaker_en,
    right_speaker_en};
  wire [7:0] pwr = {pll_power, adc_power, dac_power, en, clocks_ready};

  crpc_top #(.INIT_CYCLES(INIT), .PLL_CYCLES(PLL)) i_crpc_top (.*);

  always #25 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict;
    end
  end

  task automatic chk(input [7:0] got, input [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input [7:0] a, input [7:0] exp, input string what);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp, what);
  endtask

  // bounded wait; the lockout also has an upper limit in the checker
  task automatic wait_init;
    int n;
    n = 0;
    while (init_busy !== 1'b0 && n < INIT + 8) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, init_busy}, 8'h00, "init end");
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    idle(5);
    sys_rst = 1'b0;
    wait_init;
    chk(pwr, 8'h00, "reset power");
    rd(8'h02, 8'h00, "status");
    wr(8'h00, 8'h01);
    rd(8'h1f, 8'h00, "hp reset reg");
    rd(8'h00, 8'h01, "page reg");
    wr(8'h09, 8'hff);
    rd(8'h09, 8'hff, "power reg");
    idle(3);
    chk(pwr, 8'hfe, "powered");
    idle(PLL - 14);
    chk(pwr, 8'hfe, "clock held");
    idle(16);
    chk(pwr, 8'hff, "clock ready");
    $display("test power done");
    for (int i = 0; i < 4; i++) begin
      trip = 4'h8 >> i;
      idle(6);
      trip = 4'h0;
      chk({4'h0, en}, {4'h0, ~(4'h8 >> i)}, "tripped");
      wr(8'h00, 8'h00);
      rd(8'h02, {4'h8 >> i, 4'h2}, "trip status");
      wr(8'h00, 8'h01);
      wr(i < 2 ? 8'h1f : 8'h20, (i % 2 ? 8'h40 : 8'h80) | 8'h15);
      idle(3);
      chk({4'h0, en}, 8'h0f, "restored");
      rd(i < 2 ? 8'h1f : 8'h20, 8'h15, "self clear");
      rd(8'h09, 8'hff, "others kept");
    end
    $display("test stage reset done");
    wr(8'h09, 8'h00);
    idle(3);
    chk(pwr, 8'h00, "powered down");
    rd(8'h1f, 8'h15, "hp kept");
    rd(8'h20, 8'h15, "spk kept");
    $display("test power down done");
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    idle(3);
    chk({7'h00, init_busy}, 8'h01, "soft lockout");
    wait_init;
    rd(8'h01, 8'h00, "soft bit");
    wr(8'h7f, 8'h55);
    rd(8'h7f, 8'h00, "unmapped");
    wr(8'h00, 8'h01);
    rd(8'h1f, 8'h00, "soft cleared");
    $display("test soft reset done");
    wr(8'h09, 8'h30);
    idle(3);
    chk(pwr, 8'h60, "adc dac on");
    hw_reset_n = 1'b0;
    idle(6);
    hw_reset_n = 1'b1;
    chk({7'h00, init_busy}, 8'h01, "pin lockout");
    wait_init;
    chk(pwr, 8'h00, "pin power off");
    wr(8'h00, 8'h01);
    rd(8'h09, 8'h00, "pin cleared");
    $display("test pin reset done");
    print_verdict;
  end
endmodule // crpc_top_test
